// ==== src/fault_failsafe_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
module fault_failsafe_supervisor #(
	parameter int WDOG_BASE = supervisor_pkg::WDOG_BASE_CYC
) (
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              rst_b,
	// Register port
	input  wire logic [supervisor_pkg::ADDR_W-1:0] addr,
	input  wire logic [supervisor_pkg::DATA_W-1:0] wdata,
	input  wire logic                              wr,
	input  wire logic                              rd,
	output logic [supervisor_pkg::DATA_W-1:0]      rdata_r,
	// Mode pins
	input  wire logic                              wake,
	input  wire logic                              rst_pin_b,
	input  wire logic                              fail_safe_select,
	input  wire logic [1:0]                        fail_safe_resistor,
	input  wire logic                              direct_in,
	input  wire logic                              vdd_ok,
	// Serial link
	input  wire logic                              sclk,
	input  wire logic                              cs_b,
	input  wire logic                              si,
	output logic                                   so_r,
	output logic                                   so_oe_r,
	// Analog fault sense
	input  wire supervisor_pkg::fault_type         sense,
	// Switch control
	output logic                                   gate_on_r,
	output logic                                   fault_status_output_b_r,
	output logic                                   normal_op_r,
	output var supervisor_pkg::occ_type            occ_out_r
);
	import supervisor_pkg::*;

	// Counter must hold the longest period
	if (WDOG_BASE < 1 || WDOG_BASE > (2**WDOG_CNT_W - 1) / WDOG_SEL_MAX)
	begin : g_chk
		$error("WDOG_BASE out of range");
	end

	pin_type            pin_raw;
	pin_type            p1_r;
	pin_type            p_r;
	pin_type            pq_r;
	ctrl_type           ctrl_r;
	ctrl_type           ctrl_nxt;
	ctrl_type           ctrl_eff;
	logic [1:0]         sel_r;
	logic [1:0]         sel_nxt;
	occ_type            occ_r;
	occ_type            occ_nxt;
	fault_type          flag_r;
	fault_type          flag_nxt;
	fault_type          snap_r;
	fault_type          snap_nxt;
	fault_type          set_vec;
	mode_type           mode_r;
	mode_type           mode_nxt;
	logic               armed_r;
	logic               armed_nxt;
	logic [WDOG_CNT_W-1:0] wdog_cnt_r;
	logic [WDOG_CNT_W-1:0] wdog_cnt_nxt;
	logic [WDOG_CNT_W-1:0] wdog_lim;
	logic [CMD_W-1:0]   rx_r;
	logic [CMD_W-1:0]   rx_nxt;
	logic [CMD_W-1:0]   tx_r;
	logic [CMD_W-1:0]   tx_nxt;
	logic [3:0]         bit_cnt_r;
	logic [3:0]         bit_cnt_nxt;
	logic               tog_r;
	logic [CMD_W-1:0]   cmd_r;
	logic               ot_hold_r;
	logic               uv_latch_r;
	logic               oc_latch_r;
	logic [DATA_W-1:0]  rd_val;
	wdog_type           wdog_view;
	status_type         st_view;

	// Every pin passes two flip-flops; pq_r keeps the previous sample
	assign pin_raw = {wake, rst_pin_b, fail_safe_select, direct_in, vdd_ok,
		sclk, cs_b, si, sense, fail_safe_resistor};

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			p1_r <= '0;
			p_r <= '0;
			pq_r <= '0;
		end else begin
			p1_r <= pin_raw;
			p_r <= p1_r;
			pq_r <= p_r;
		end
	end

	// Edge detection on the synchronised pins
	wire vdd = p_r.vdd_ok;
	wire sclk_rise = p_r.sclk & !pq_r.sclk & !p_r.cs_b;
	wire cs_fall = pq_r.cs_b & !p_r.cs_b;
	wire cs_rise = !pq_r.cs_b & p_r.cs_b;
	wire wake_rise = p_r.wake & !pq_r.wake;
	wire rstp_rise = p_r.rst_b & !pq_r.rst_b;
	wire both_low = !p_r.wake & !p_r.rst_b;

	// Mode decode
	wire in_sleep = mode_r == MODE_SLEEP;
	wire in_norm = mode_r == MODE_NORMAL;
	wire in_fs = mode_r == MODE_FAILSAFE;

	// Sleep hides stored settings without losing them
	assign ctrl_eff = in_sleep ? CTRL_RST : ctrl_r;

	// Output command; fail-safe ignores direct input and settings
	wire fs_on = p_r.res == RES_ON;
	wire cmd_on = in_sleep ? 1'b0 :
		in_fs ? fs_on :
		(p_r.din | ctrl_eff.out_on);

	// Fault detection terms
	wire ot_set = gate_on_r & p_r.sense.ot;
	wire ov_act = p_r.sense.ov & !ctrl_eff.high_supply_guard_off;
	wire uv_act = p_r.sense.uv & !ctrl_eff.low_supply_guard_off;
	// Open load stays quiet once software gives up on it
	wire ol_act = p_r.sense.ol & !gate_on_r & !in_sleep &
		!ctrl_eff.open_load_detect_off;
	wire oc_set = gate_on_r & p_r.sense.oc;

	// Anything that forces the switch off
	wire blk = ot_set | ot_hold_r | ov_act | uv_act | uv_latch_r |
		oc_set | oc_latch_r;
	wire gate_nxt = cmd_on & !blk;
	// Open load pulls the pin but never blocks the switch
	wire fault_any = blk | ol_act;

	// Battery in range, reset pin high, no fault
	wire norm_nxt = in_norm & p_r.rst_b & !p_r.sense.uv &
		!p_r.sense.ov & !fault_any;

	// Latching fault holds
	wire ot_hold_nxt = ot_set | (ot_hold_r & p_r.sense.ot);
	// A latched low battery only clears once the command goes off
	wire uv_latch_nxt = uv_act | (uv_latch_r & cmd_on);
	// Overcurrent stays off until commanded off and on again
	wire oc_latch_nxt = oc_set | (oc_latch_r & cmd_on);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ot_hold_r <= 1'b0;
			uv_latch_r <= 1'b0;
			oc_latch_r <= 1'b0;
			gate_on_r <= 1'b0;
			fault_status_output_b_r <= 1'b1;
			normal_op_r <= 1'b0;
		end else begin
			ot_hold_r <= ot_hold_nxt;
			uv_latch_r <= uv_latch_nxt;
			oc_latch_r <= oc_latch_nxt;
			gate_on_r <= gate_nxt;
			fault_status_output_b_r <= !fault_any;
			normal_op_r <= norm_nxt;
		end
	end

	// Serial transfer: a valid one is exactly eight clocks under select
	wire done = cs_rise & (bit_cnt_r == BITS_PER_CMD);
	wire tog_chg = done & (rx_r[TOGGLE_POS] != tog_r);

	// Sticky flags; a new event wins over the clear of a read
	assign set_vec = {oc_set, ol_act, uv_act, ov_act, ot_set};
	assign flag_nxt = set_vec |
		(flag_r & ~(done ? snap_r : '0));

	// Shift register; the reported snapshot is taken at select
	always_comb begin
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		bit_cnt_nxt = bit_cnt_r;
		snap_nxt = snap_r;
		if (cs_fall) begin
			tx_nxt = CMD_W'(flag_r);
			snap_nxt = flag_r;
			bit_cnt_nxt = '0;
		end else if (sclk_rise) begin
			rx_nxt = {rx_r[CMD_W-2:0], p_r.si};
			tx_nxt = {tx_r[CMD_W-2:0], 1'b0};
			if (bit_cnt_r != '1) begin
				bit_cnt_nxt = bit_cnt_r + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rx_r <= '0;
			tx_r <= '0;
			bit_cnt_r <= '0;
			snap_r <= '0;
			flag_r <= '0;
		end else begin
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			snap_r <= snap_nxt;
			flag_r <= flag_nxt;
		end
	end

	// Serial output and last accepted command
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
			tog_r <= 1'b0;
			cmd_r <= '0;
		end else begin
			so_r <= tx_nxt[CMD_W-1];
			so_oe_r <= !p_r.cs_b;
			if (done) begin
				tog_r <= rx_r[TOGGLE_POS];
				cmd_r <= rx_r;
			end
		end
	end

	// Watchdog arm, count and expiry
	assign armed_nxt = p_r.fss & (wake_rise | rstp_rise |
		(armed_r & !in_sleep));
	wire wdog_run = armed_r & in_norm;
	assign wdog_lim = WDOG_CNT_W'((WDOG_BASE << sel_r) - 1);
	wire wdog_exp = wdog_run & (wdog_cnt_r >= wdog_lim);
	assign wdog_cnt_nxt = (!wdog_run | tog_chg | wdog_exp) ? '0 :
		wdog_cnt_r + WDOG_CNT_W'(1);
	// A grounded selector or an open resistor never enters fail-safe
	wire go_fs = wdog_exp & p_r.fss & (p_r.res != RES_NONE);

	// Mode machine; fail-safe is left by reinitialisation or by grounding the selector
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			MODE_SLEEP: begin
				if (!both_low) begin
					mode_nxt = MODE_NORMAL;
				end
			end
			MODE_NORMAL: begin
				if (both_low) begin
					mode_nxt = MODE_SLEEP;
				end else if (go_fs) begin
					mode_nxt = MODE_FAILSAFE;
				end
			end
			MODE_FAILSAFE: begin
				if (both_low) begin
					mode_nxt = MODE_SLEEP;
				end else if (!p_r.fss) begin
					mode_nxt = MODE_NORMAL;
				end
			end
			default: begin
				mode_nxt = MODE_SLEEP;
			end
		endcase
	end
	wire enter_fs = (mode_nxt == MODE_FAILSAFE) & !in_fs;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mode_r <= MODE_SLEEP;
			armed_r <= 1'b0;
			wdog_cnt_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			armed_r <= armed_nxt;
			wdog_cnt_r <= wdog_cnt_nxt;
		end
	end

	// Register writes; losing the logic supply forces defaults
	wire wr_ctrl = wr & (addr == ADDR_CTRL);
	wire wr_wdog = wr & (addr == ADDR_WDOG);
	wire wr_occ = wr & (addr == ADDR_OCCFG);
	assign ctrl_nxt = !vdd ? CTRL_RST :
		wr_ctrl ? ctrl_type'(wdata[$bits(ctrl_type)-1:0]) : ctrl_r;
	assign sel_nxt = !vdd ? WDOG_SEL_RST :
		wr_wdog ? wdata[1:0] : sel_r;
	// Only the overcurrent settings fall back on entering fail-safe
	assign occ_nxt = (!vdd | enter_fs) ? OCC_RST :
		wr_occ ? occ_type'(wdata[$bits(occ_type)-1:0]) : occ_r;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_r <= CTRL_RST;
			sel_r <= WDOG_SEL_RST;
			occ_r <= OCC_RST;
			occ_out_r <= OCC_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			sel_r <= sel_nxt;
			occ_r <= occ_nxt;
			occ_out_r <= in_sleep ? OCC_RST : occ_r;
		end
	end

	// Read views; reading never clears anything here
	assign wdog_view = {in_fs, sel_r};
	assign st_view = {cmd_r, 3'h0, flag_r, 4'h0, armed_r, normal_op_r,
		mode_r};
	assign rd_val = (addr == ADDR_CTRL) ? DATA_W'(ctrl_r) :
		(addr == ADDR_WDOG) ? DATA_W'(wdog_view) :
		(addr == ADDR_OCCFG) ? DATA_W'(occ_r) :
		(addr == ADDR_STATUS) ? DATA_W'(st_view) : '0;

	// Read data stand in each cycle after a cycle with rd high, zero otherwise
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rd ? rd_val : '0;
		end
	end

	// Checks on the design's own behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	AST_NORMAL_OP: assert property (
		(in_norm && p_r.rst_b && !fault_any && !p_r.sense.uv &&
		!p_r.sense.ov) |=> normal_op_r)
		else $error("normal operation flag missing");
	AST_ARM: assert property (
		($rose(p_r.wake) && p_r.fss) |=> armed_r)
		else $error("watchdog not armed on wake edge");
	AST_EXPIRE: assert property (
		(go_fs && in_norm && !both_low) |=> in_fs)
		else $error("watchdog expiry did not enter fail-safe");
	AST_FS_ON: assert property (
		(in_fs && fs_on && !blk) |=> gate_on_r)
		else $error("fail-safe on selection not driving output");
	AST_FS_OFF: assert property (
		(in_fs && !fs_on) |=> !gate_on_r)
		else $error("fail-safe off selection left output on");
	AST_OCC_DEFAULT: assert property (
		(in_norm && go_fs && !both_low) |=> (occ_r == OCC_RST))
		else $error("overcurrent settings kept on fail-safe entry");
	AST_EXPIRED_BIT: assert property (
		rd && addr == ADDR_WDOG |=> rdata_r[2] == $past(in_fs))
		else $error("expired flag does not match fail-safe");
	AST_FS_EXIT: assert property (
		(in_fs && both_low) |=> in_sleep)
		else $error("fail-safe not left on wake and reset low");
	AST_GROUNDED: assert property (
		!p_r.fss |=> !in_fs)
		else $error("fail-safe with selector grounded");
	AST_VDD_LOSS: assert property (
		!vdd |=> (ctrl_r == CTRL_RST && sel_r == WDOG_SEL_RST))
		else $error("registers kept without logic supply");
	AST_FAULT_PIN: assert property (
		fault_any |=> !fault_status_output_b_r)
		else $error("fault pin not pulled low");
	AST_READ_CLEAR: assert property (
		(done && flag_r == snap_r && set_vec == '0) |=> flag_r == '0)
		else $error("flags not cleared by valid read");
	AST_OT_FLAG: assert property (
		ot_set |=> (flag_r.ot && !gate_on_r))
		else $error("over temp not flagged or not turned off");
	AST_UV_HOLD: assert property (
		(uv_latch_r && cmd_on) |=> (!fault_status_output_b_r &&
		!gate_on_r))
		else $error("low battery hold released early");
	AST_TOGGLE: assert property (
		(tog_chg && wdog_run) |=> wdog_cnt_r == '0)
		else $error("toggle did not restart watchdog");
	AST_SLEEP_OFF: assert property (
		in_sleep |=> !gate_on_r)
		else $error("output on in sleep");

	// Main scenarios
	COV_FS_ENTRY: cover property (in_norm ##1 in_fs);
	COV_FS_EXIT: cover property (in_fs ##1 in_sleep);
	COV_READ: cover property (done && snap_r != '0);
	COV_UV_RECOVER: cover property (uv_latch_r ##1 !uv_latch_r);
endmodule
`default_nettype wire

// ==== src/supervisor_pkg.sv ====
`default_nettype none
package supervisor_pkg;
	// Timing of the watchdog
	localparam int CLK_PERIOD_NS = 5;
	localparam int WDOG_BASE_MS = 10;
	localparam int WDOG_BASE_CYC = WDOG_BASE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int WDOG_CNT_W = 24;
	localparam int WDOG_SEL_MAX = 8;
	// Serial command framing
	localparam int CMD_W = 8;
	localparam int TOGGLE_POS = 7;
	localparam logic [3:0] BITS_PER_CMD = 4'h8;
	// Register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_WDOG = 8'h04;
	localparam logic [7:0] ADDR_OCCFG = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	// Fail-safe resistor selection
	localparam logic [1:0] RES_NONE = 2'h0;
	localparam logic [1:0] RES_OFF = 2'h1;
	localparam logic [1:0] RES_ON = 2'h2;
	typedef enum logic [1:0] {
		MODE_SLEEP    = 2'h0,
		MODE_NORMAL   = 2'h1,
		MODE_FAILSAFE = 2'h2
	} mode_type;
	// Fault flags; over temp in bit 0, supply high in bit 1
	typedef struct packed {
		logic oc;
		logic ol;
		logic uv;
		logic ov;
		logic ot;
	} fault_type;
	typedef struct packed {
		logic      wake;
		logic      rst_b;
		logic      fss;
		logic      din;
		logic      vdd_ok;
		logic      sclk;
		logic      cs_b;
		logic      si;
		fault_type sense;
		logic [1:0] res;
	} pin_type;
	typedef struct packed {
		logic open_load_detect_off;
		logic low_supply_guard_off;
		logic high_supply_guard_off;
		logic out_on;
	} ctrl_type;
	typedef struct packed {
		logic       watchdog_expired_flag;
		logic [1:0] period_sel;
	} wdog_type;
	typedef struct packed {
		logic [1:0] overcurrent_low_time;
		logic       overcurrent_high_level;
		logic [2:0] overcurrent_low_level;
	} occ_type;
	typedef struct packed {
		logic [7:0] last_cmd;
		logic [2:0] rsvd_hi;
		fault_type  flags;
		logic [3:0] rsvd_lo;
		logic       armed;
		logic       normal_op;
		mode_type   mode;
	} status_type;
	// Reset values
	localparam ctrl_type CTRL_RST = 4'h0;
	localparam logic [1:0] WDOG_SEL_RST = 2'h0;
	localparam occ_type OCC_RST = 6'h00;
endpackage
`default_nettype wire

// ==== tb/fault_failsafe_supervisor_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module fault_failsafe_supervisor_bench;
	import supervisor_pkg::*;
	localparam int WB = 200;
	localparam logic [7:0] T_RC = {RES_OFF, RES_ON, RES_ON, RES_NONE};
	localparam logic [3:0] T_FS = 4'hd;
	localparam logic [3:0] T_C = 4'h9;
	localparam logic [3:0] T_G = 4'h5;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata_r;
	logic        wake = 1'b0;
	logic        rst_pin_b = 1'b0;
	logic        fss = 1'b0;
	logic [1:0]  res = 2'h0;
	logic        direct_in = 1'b0;
	logic        vdd_ok = 1'b1;
	fault_type   sense = 5'h00;
	occ_type     occ_out_r;
	logic        so_r, so_oe_r, so_last = 1'b0;
	logic        gate_on_r, fault_status_output_b_r, normal_op_r;
	wire logic   sclk, cs_b, si, so_line;
	int          n_errors = 0;
	int          n_checks = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;
	// Undriven serial output shows the inverse of its last value
	always @(posedge clk) if (so_oe_r) so_last <= so_r;
	assign so_line = so_oe_r ? so_r : ~so_last;

	fault_failsafe_supervisor #(.WDOG_BASE(WB)) i_fault_failsafe_supervisor (
		.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata_r(rdata_r), .wake(wake), .rst_pin_b(rst_pin_b),
		.fail_safe_select(fss), .fail_safe_resistor(res),
		.direct_in(direct_in), .vdd_ok(vdd_ok), .sclk(sclk), .cs_b(cs_b),
		.si(si), .so_r(so_r), .so_oe_r(so_oe_r), .sense(sense),
		.gate_on_r(gate_on_r),
		.fault_status_output_b_r(fault_status_output_b_r),
		.normal_op_r(normal_op_r), .occ_out_r(occ_out_r));
	spi_host i_spi_host (.sclk(sclk), .cs_b(cs_b), .si(si), .so(so_line));

	task automatic check(input string nm, input logic [31:0] seen, e);
		n_checks++;
		if (seen !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read strobe for one cycle, data taken in the cycle after it
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] m, e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(nm, rdata_r & m, e);
	endtask
	task automatic set(input logic w, r, f, input logic [1:0] c);
		@(posedge clk);
		wake <= w;
		rst_pin_b <= r;
		fss <= f;
		res <= c;
		cyc(8);
	endtask
	task automatic sn(input fault_type v);
		@(posedge clk);
		sense <= v;
		cyc(8);
	endtask
	// Gate, fault pin and normal flag together
	task automatic pc(input logic [2:0] e);
		check("pins", {gate_on_r, fault_status_output_b_r, normal_op_r}, e);
	endtask
	task automatic xs(input logic [7:0] c, input int nb, input logic [7:0] e);
		logic [7:0] rx;
		i_spi_host.xfer(c, nb, rx);
		check("so_byte", rx, e);
	endtask
	task automatic stop_test;
		$display("Checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		#200000;
		n_errors++;
		$display("Error run did not finish");
		stop_test();
	end

	// Main sequence
	initial begin
		logic fs;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		cyc(2);
		pc(3'b010);
		rchk("ctrl", ADDR_CTRL, 32'hffffffff, 32'h0);
		rchk("wdog", ADDR_WDOG, 32'hffffffff, 32'h0);
		rchk("occ", ADDR_OCCFG, 32'hffffffff, 32'h0);
		rchk("unmapped", 8'h10, 32'hffffffff, 32'h0);
		// Arm, then keep the watchdog fed past two periods
		set(1'b0, 1'b0, 1'b1, RES_OFF);
		set(1'b1, 1'b1, 1'b1, RES_OFF);
		rchk("armed", ADDR_STATUS, 32'h8, 32'h8);
		rchk("normal", ADDR_STATUS, 32'h7, 32'h5);
		wr_reg(ADDR_WDOG, 32'h4);
		rchk("wdog_ro", ADDR_WDOG, 32'h4, 32'h0);
		for (int k = 0; k < 4; k++) begin
			xs({~k[0], 7'h00}, 8, 8'h00);
			cyc(20);
		end
		rchk("fed", ADDR_STATUS, 32'h3, MODE_NORMAL);
		// Expiry per resistor code and select level
		for (int i = 0; i < 4; i++) begin
			fs = i >= 2;
			set(1'b0, 1'b0, T_FS[i], T_RC[2*i +: 2]);
			rchk("sleep", ADDR_STATUS, 32'h3, MODE_SLEEP);
			check("sleep_out", {gate_on_r, occ_out_r}, 7'h00);
			set(1'b1, 1'b1, T_FS[i], T_RC[2*i +: 2]);
			wr_reg(ADDR_CTRL, {31'h0, T_C[i]});
			wr_reg(ADDR_OCCFG, 32'h3f);
			cyc(WB + 60);
			rchk("mode", ADDR_STATUS, 32'h3,
				fs ? MODE_FAILSAFE : MODE_NORMAL);
			rchk("expired", ADDR_WDOG, 32'h4, {fs, 2'b00});
			rchk("occ", ADDR_OCCFG, 32'h3f, fs ? 32'h0 : 32'h3f);
			check("occ_out", occ_out_r, fs ? 6'h00 : 6'h3f);
			rchk("ctrl", ADDR_CTRL, 32'h1, T_C[i]);
			check("gate", gate_on_r, T_G[i]);
		end
		set(1'b1, 1'b1, 1'b0, RES_OFF);
		rchk("exit", ADDR_STATUS, 32'h3, MODE_NORMAL);
		// Over temperature and over voltage
		wr_reg(ADDR_CTRL, 32'h1);
		sn(5'h01);
		pc(3'b000);
		sn(5'h00);
		pc(3'b111);
		xs(8'h00, 8, 8'h01);
		xs(8'h00, 8, 8'h00);
		sn(5'h02);
		pc(3'b000);
		sn(5'h00);
		xs(8'h00, 4, 8'h00);
		xs(8'h00, 8, 8'h02);
		wr_reg(ADDR_CTRL, 32'h3);
		sn(5'h02);
		// Guard off keeps the switch on, but a high battery is not normal
		pc(3'b110);
		sn(5'h00);
		xs(8'h00, 8, 8'h00);
		// Under voltage, commanded on and off
		wr_reg(ADDR_CTRL, 32'h1);
		sn(5'h04);
		pc(3'b000);
		sn(5'h00);
		pc(3'b000);
		wr_reg(ADDR_CTRL, 32'h0);
		wr_reg(ADDR_CTRL, 32'h1);
		cyc(6);
		pc(3'b111);
		xs(8'h00, 8, 8'h04);
		wr_reg(ADDR_CTRL, 32'h0);
		sn(5'h04);
		sn(5'h00);
		pc(3'b011);
		xs(8'h00, 8, 8'h04);
		wr_reg(ADDR_CTRL, 32'h5);
		sn(5'h04);
		pc(3'b110);
		sn(5'h00);
		xs(8'h00, 8, 8'h00);
		// Open load, sensed only while off
		wr_reg(ADDR_CTRL, 32'h1);
		sn(5'h08);
		pc(3'b111);
		wr_reg(ADDR_CTRL, 32'h0);
		cyc(8);
		pc(3'b000);
		xs(8'h00, 8, 8'h08);
		xs(8'h00, 8, 8'h08);
		sn(5'h00);
		pc(3'b011);
		xs(8'h00, 8, 8'h08);
		xs(8'h00, 8, 8'h00);
		wr_reg(ADDR_CTRL, 32'h8);
		sn(5'h08);
		pc(3'b011);
		sn(5'h00);
		// Over current stays latched until off then on
		wr_reg(ADDR_CTRL, 32'h1);
		sn(5'h10);
		pc(3'b000);
		sn(5'h00);
		pc(3'b000);
		wr_reg(ADDR_CTRL, 32'h0);
		wr_reg(ADDR_CTRL, 32'h1);
		cyc(6);
		pc(3'b111);
		xs(8'h00, 8, 8'h10);
		// Logic supply loss
		@(posedge clk);
		vdd_ok <= 1'b0;
		cyc(8);
		rchk("ctrl_lost", ADDR_CTRL, 32'hf, 32'h0);
		@(posedge clk);
		direct_in <= 1'b1;
		cyc(8);
		check("direct", gate_on_r, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire

// ==== tb/spi_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_host (
	// Serial link
	output logic     sclk,
	output logic     cs_b,
	output logic     si,
	input  wire logic so
);
	// Clock stands still and select idles high outside frames
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		si = 1'b0;
	end
	// One frame, MSB first; fewer than 8 edges gives a refused frame
	task automatic xfer(input logic [7:0] cmd, input int nb,
		output logic [7:0] rx);
		rx = 8'h00;
		cs_b = 1'b0;
		for (int i = 7; i > 7 - nb; i--) begin
			si = cmd[i];
			#24;
			rx[i] = so;
			sclk = 1'b1;
			#24;
			sclk = 1'b0;
		end
		#24;
		cs_b = 1'b1;
		si = ~si; // Released line must not hold the last bit
		#40;
	endtask
endmodule
`default_nettype wire
